// ### bccs_consts.svh
// constant definitions for the charger control and status register bank
`ifndef BCCS_CONSTS_SVH
`define BCCS_CONSTS_SVH

// register offsets on the serial host register port
`define BCCS_OFS_STATUS      8'h03
`define BCCS_OFS_CONTROL_A   8'h04
`define BCCS_OFS_CONTROL_B   8'h05

// reset values
`define BCCS_RST_CONTROL_A   8'hb1
`define BCCS_RST_CONTROL_B   8'h80
`define BCCS_RST_STATUS      8'h00

// status bit positions
`define BCCS_ST_DIE_HEAT     7
`define BCCS_ST_LOAD_LOOP    6
`define BCCS_ST_BATT_PAUSE   5
`define BCCS_ST_END_CURRENT  4
`define BCCS_ST_CHARGING     3
`define BCCS_ST_CHG_TIMEOUT  2
`define BCCS_ST_PRE_TIMEOUT  1
`define BCCS_ST_THERM_FAULT  0

// control a field positions
`define BCCS_CA_TIMER_HI     7
`define BCCS_CA_TIMER_LO     6
`define BCCS_CA_TIMERS_ON    5
`define BCCS_CA_CURVE        4
`define BCCS_CA_RESTART      3
`define BCCS_CA_TERM_OFF     2
`define BCCS_CA_HOLD         1
`define BCCS_CA_CHARGER_ON   0

// control b field positions
`define BCCS_CB_SLOW_TIMERS  7
`define BCCS_CB_PRE_SELECT   6
`define BCCS_CB_VOLT_HI      5
`define BCCS_CB_VOLT_LO      4

// fast-charge timer codes and lengths in hours
`define BCCS_TMR_CODE_4H     2'b00
`define BCCS_TMR_CODE_5H     2'b01
`define BCCS_TMR_CODE_6H     2'b10
`define BCCS_TMR_HOURS_4     4
`define BCCS_TMR_HOURS_5     5
`define BCCS_TMR_HOURS_6     6
`define BCCS_TMR_HOURS_8     8
`define BCCS_SEC_PER_HOUR    3600

// charge voltage codes and levels in millivolts
`define BCCS_VOLT_CODE_4100  2'b00
`define BCCS_VOLT_CODE_4150  2'b01
`define BCCS_VOLT_MV_4100    13'h1004
`define BCCS_VOLT_MV_4150    13'h1036
`define BCCS_VOLT_MV_4200    13'h1068

// precharge threshold levels in millivolts
`define BCCS_PRE_MV_2900     12'hb54
`define BCCS_PRE_MV_2500     12'h9c4

// timer tick: one second at the device clock rate
`define BCCS_TICK_TIME_MS    1000
`define BCCS_CLK_MHZ         100
`define BCCS_TICK_CYCLES     (`BCCS_TICK_TIME_MS * 1000 * `BCCS_CLK_MHZ)
`define BCCS_PRE_SECONDS     16'h0708

`endif

// ### bccs_pkg.sv
// types shared by the charger control and status register bank
package bccs_pkg;

    typedef logic [7:0]  bccs_byte_t;
    typedef logic [15:0] bccs_secs_t;
    typedef logic [31:0] bccs_tick_t;

    // charge timing phase
    typedef enum logic [2:0]
    {
        BCCS_IDLE    = 3'b001,
        BCCS_RUNNING = 3'b010,
        BCCS_EXPIRED = 3'b100
    } bccs_phase_e;

endpackage : bccs_pkg

// ### bccs_regs.sv
// charger control and status register bank with safety timers
//
// Overview of operation
// - status bit 7: die heat cuts current
// - status bit 6: load-priority loop reducing current
// - status bit 5: battery heat pauses charging
// - status bit 4: end current reached, charging stopped
// - status bit 3: charging, even in loops
// - status bit 2: any charge timer expired
// - status bit 1: precharge timer expired
// - status bit 0: thermistor missing or out-of-range
// - timer field picks 4/5/6/8 h, 6 h reset
// - timers-on bit 0 disables both timers
// - curve bit selects 100k or 10k thermistor
// - termination-off bit keeps charger on
// - hold bit pauses both timers
// - charger-on bit enables charger, reset 1
// - slow bit halves timer rate in loops
// - precharge threshold 2.9 V or 2.5 V
// - voltage field 4.1, 4.15, 4.2 V
`timescale 1ns/10ps
`include "bccs_consts.svh"

module bccs_regs
    import bccs_pkg::*;
#(
    parameter bccs_tick_t TICK_CYCLES = `BCCS_TICK_CYCLES,
    parameter bccs_secs_t PRE_SECONDS = `BCCS_PRE_SECONDS
)
(
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    output logic      [7:0]   reg_rdata,
    input  wire logic         die_heat_cutback_flag,
    input  wire logic         load_priority_loop_active,
    input  wire logic         battery_heat_pause_flag,
    input  wire logic         end_current_reached,
    input  wire logic         charging_now,
    input  wire logic         in_precharge,
    input  wire logic         thermistor_fault_flag,
    output logic              charger_on,
    output logic              charger_restart,
    output logic              termination_enabled,
    output logic              thermistor_curve_select,
    output logic              precharge_threshold_select,
    output logic      [11:0]  precharge_threshold_mv,
    output logic      [1:0]   charge_voltage_select,
    output logic      [12:0]  charge_voltage_mv,
    output logic              charge_timer_expired,
    output logic              precharge_timer_expired
);

    ////////////////////////////////////////////////////////////////////////////
    // decode functions

    // fast-charge timer length in seconds
    function automatic bccs_secs_t fast_seconds(input logic [1:0] code);
        int hours;
        case (code)
            `BCCS_TMR_CODE_4H: hours = `BCCS_TMR_HOURS_4;
            `BCCS_TMR_CODE_5H: hours = `BCCS_TMR_HOURS_5;
            `BCCS_TMR_CODE_6H: hours = `BCCS_TMR_HOURS_6;
            default:           hours = `BCCS_TMR_HOURS_8;
        endcase
        return bccs_secs_t'(hours * `BCCS_SEC_PER_HOUR);
    endfunction : fast_seconds

    // charge voltage in millivolts
    function automatic logic [12:0] volt_mv(input logic [1:0] code);
        case (code)
            `BCCS_VOLT_CODE_4100: volt_mv = `BCCS_VOLT_MV_4100;
            `BCCS_VOLT_CODE_4150: volt_mv = `BCCS_VOLT_MV_4150;
            default:              volt_mv = `BCCS_VOLT_MV_4200;
        endcase
    endfunction : volt_mv

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [6:0] sync1_r;
    logic [6:0] sync2_r;

    // two flops on every analog-loop flag
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
        end
        else
        begin
            sync1_r <= {die_heat_cutback_flag, load_priority_loop_active,
                        battery_heat_pause_flag, end_current_reached,
                        charging_now, in_precharge, thermistor_fault_flag};
            sync2_r <= sync1_r;
        end
    end

    logic die_heat;
    logic load_loop;
    logic batt_pause;
    logic end_cur;
    logic charging;
    logic pre_phase;
    logic therm_fault;

    assign {die_heat, load_loop, batt_pause, end_cur,
            charging, pre_phase, therm_fault} = sync2_r;

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    bccs_byte_t ctrl_a_r;
    bccs_byte_t ctrl_b_r;

    // host writes; reserved bits of control b store as written
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ctrl_a_r <= `BCCS_RST_CONTROL_A;
            ctrl_b_r <= `BCCS_RST_CONTROL_B;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `BCCS_OFS_CONTROL_A)
                ctrl_a_r <= reg_wdata;
            if (reg_addr == `BCCS_OFS_CONTROL_B)
                ctrl_b_r <= reg_wdata;
        end
    end

    logic timers_on;
    logic hold_timers;
    logic slow_timers;
    logic restart_bit;
    logic restart_r;
    logic restart_rise;

    assign timers_on   = ctrl_a_r[`BCCS_CA_TIMERS_ON];
    assign hold_timers = ctrl_a_r[`BCCS_CA_HOLD];
    assign slow_timers = ctrl_b_r[`BCCS_CB_SLOW_TIMERS];
    assign restart_bit = ctrl_a_r[`BCCS_CA_RESTART];

    // restart acts on the host setting the bit; it stays held until cleared
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            restart_r <= 1'b0;
        else
            restart_r <= restart_bit;
    end

    assign restart_rise = restart_bit & ~restart_r;

    ////////////////////////////////////////////////////////////////////////////
    // one-second tick with dynamic slowdown

    bccs_tick_t tick_cnt_r;
    logic       tick;
    logic       half_r;
    logic       timer_tick;

    // free-running prescaler
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            tick_cnt_r <= 32'h0000_0000;
        else if (tick)
            tick_cnt_r <= 32'h0000_0000;
        else
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end

    assign tick = (tick_cnt_r == TICK_CYCLES - 32'h0000_0001);

    // every other tick is dropped while a loop runs and the slow bit is set
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            half_r <= 1'b0;
        else if (tick)
            half_r <= ~half_r;
    end

    assign timer_tick = tick & (~(slow_timers & (die_heat | load_loop)) | half_r);

    ////////////////////////////////////////////////////////////////////////////
    // precharge and fast-charge safety timers

    bccs_phase_e phase_r;
    bccs_secs_t  pre_secs_r;
    bccs_secs_t  fast_secs_r;
    logic        chg_tout_r;
    logic        pre_tout_r;
    logic        count_en;
    logic        timer_clear;
    logic        pre_hit;
    logic        fast_hit;

    // timers count only while charging, enabled and not held
    assign count_en    = timer_tick & charging & timers_on & ~hold_timers;
    assign timer_clear = restart_rise | ~timers_on | ~ctrl_a_r[`BCCS_CA_CHARGER_ON];
    assign pre_hit     = count_en & pre_phase & (pre_secs_r + 16'h0001 >= PRE_SECONDS);
    assign fast_hit    = count_en & ~pre_phase
                       & (fast_secs_r + 16'h0001 >= fast_seconds(
                             ctrl_a_r[`BCCS_CA_TIMER_HI:`BCCS_CA_TIMER_LO]));

    // timing phase
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            phase_r <= BCCS_IDLE;
        else
        begin
            case (phase_r)
                BCCS_IDLE:
                    if (!timer_clear && charging)
                        phase_r <= BCCS_RUNNING;
                BCCS_RUNNING:
                    if (timer_clear)
                        phase_r <= BCCS_IDLE;
                    else if (pre_hit || fast_hit)
                        phase_r <= BCCS_EXPIRED;
                BCCS_EXPIRED:
                    if (timer_clear)
                        phase_r <= BCCS_IDLE;
                default:
                    phase_r <= BCCS_IDLE;
            endcase
        end
    end

    // elapsed seconds per timer
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pre_secs_r  <= 16'h0000;
            fast_secs_r <= 16'h0000;
        end
        else if (timer_clear || phase_r == BCCS_IDLE)
        begin
            pre_secs_r  <= 16'h0000;
            fast_secs_r <= 16'h0000;
        end
        else if (phase_r == BCCS_RUNNING && count_en)
        begin
            if (pre_phase)
                pre_secs_r <= pre_secs_r + 16'h0001;
            else
                fast_secs_r <= fast_secs_r + 16'h0001;
        end
    end

    // expiry flags; an expiry in the clearing cycle wins
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            chg_tout_r <= 1'b0;
            pre_tout_r <= 1'b0;
        end
        else if (phase_r == BCCS_RUNNING && (pre_hit || fast_hit))
        begin
            chg_tout_r <= 1'b1;
            pre_tout_r <= pre_hit;
        end
        else if (timer_clear)
        begin
            chg_tout_r <= 1'b0;
            pre_tout_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs to the analog charger

    logic term_off;

    assign term_off = ctrl_a_r[`BCCS_CA_TERM_OFF];

    // settings and the gated enable come from flops
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            charger_on                 <= 1'b0;
            charger_restart            <= 1'b0;
            termination_enabled        <= 1'b0;
            thermistor_curve_select    <= 1'b0;
            precharge_threshold_select <= 1'b0;
            precharge_threshold_mv     <= `BCCS_PRE_MV_2900;
            charge_voltage_select      <= 2'b00;
            charge_voltage_mv          <= `BCCS_VOLT_MV_4100;
            charge_timer_expired       <= 1'b0;
            precharge_timer_expired    <= 1'b0;
        end
        else
        begin
            charger_on <= ctrl_a_r[`BCCS_CA_CHARGER_ON] & ~restart_bit
                        & (~chg_tout_r | term_off);
            charger_restart            <= restart_bit;
            termination_enabled        <= ~term_off;
            thermistor_curve_select    <= ctrl_a_r[`BCCS_CA_CURVE];
            precharge_threshold_select <= ctrl_b_r[`BCCS_CB_PRE_SELECT];
            precharge_threshold_mv     <= ctrl_b_r[`BCCS_CB_PRE_SELECT]
                                        ? `BCCS_PRE_MV_2500 : `BCCS_PRE_MV_2900;
            charge_voltage_select      <= ctrl_b_r[`BCCS_CB_VOLT_HI:`BCCS_CB_VOLT_LO];
            charge_voltage_mv <= volt_mv(ctrl_b_r[`BCCS_CB_VOLT_HI:`BCCS_CB_VOLT_LO]);
            charge_timer_expired       <= chg_tout_r;
            precharge_timer_expired    <= pre_tout_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status and read data

    bccs_byte_t status;

    // live condition; writes to its offset are ignored, but the termination-off bit masks bit 4
    always_comb
    begin
        status = `BCCS_RST_STATUS;
        status[`BCCS_ST_DIE_HEAT]    = die_heat;
        status[`BCCS_ST_LOAD_LOOP]   = load_loop;
        status[`BCCS_ST_BATT_PAUSE]  = batt_pause;
        status[`BCCS_ST_END_CURRENT] = end_cur & ~term_off;
        status[`BCCS_ST_CHARGING]    = charging;
        status[`BCCS_ST_CHG_TIMEOUT] = chg_tout_r;
        status[`BCCS_ST_PRE_TIMEOUT] = pre_tout_r;
        status[`BCCS_ST_THERM_FAULT] = therm_fault;
    end

    // registered read data, zero for unmapped offsets
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `BCCS_OFS_STATUS:    reg_rdata <= status;
                `BCCS_OFS_CONTROL_A: reg_rdata <= ctrl_a_r;
                `BCCS_OFS_CONTROL_B: reg_rdata <= ctrl_b_r;
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : bccs_regs

// ### bccs_regs_props.sv
// concurrent checks on the charger register bank ports
`timescale 1ns/10ps
module bccs_regs_props
    import bccs_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        charger_on,
    input wire logic        charger_restart,
    input wire logic        termination_enabled,
    input wire logic        thermistor_curve_select,
    input wire logic        precharge_threshold_select,
    input wire logic [11:0] precharge_threshold_mv,
    input wire logic [1:0]  charge_voltage_select,
    input wire logic [12:0] charge_voltage_mv,
    input wire logic        charge_timer_expired,
    input wire logic        precharge_timer_expired
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    // a write to control a, then the derived outputs two edges on
    sequence s_wr_a;
        reg_wr && reg_addr == 8'h04;
    endsequence
    chk_curve_follows: assert property (s_wr_a |=> ##1
        thermistor_curve_select == $past(reg_wdata[4], 2))
        else $error("curve select not taken from write");
    chk_restart_follows: assert property (s_wr_a |=> ##1
        charger_restart == $past(reg_wdata[3], 2))
        else $error("restart output not taken from write");
    chk_term_follows: assert property (s_wr_a |=> ##1
        termination_enabled == !$past(reg_wdata[2], 2))
        else $error("termination output not taken from write");
    chk_charger_off: assert property (s_wr_a ##0 !reg_wdata[0] |=> ##1 !charger_on)
        else $error("charger stays on after disable");
    chk_volt_decode: assert property (charge_voltage_mv ==
        (charge_voltage_select == 2'b00 ? 13'h1004 :
        charge_voltage_select == 2'b01 ? 13'h1036 : 13'h1068))
        else $error("charge voltage decode wrong");
    chk_pre_decode: assert property (precharge_threshold_mv ==
        (precharge_threshold_select ? 12'h09c4 : 12'h0b54))
        else $error("precharge threshold decode wrong");
    chk_timeout_pair: assert property (precharge_timer_expired |-> charge_timer_expired)
        else $error("precharge expiry without timer expiry");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h05 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
endmodule : bccs_regs_props

bind bccs_regs bccs_regs_props bccs_regs_props_inst (.clock(clock), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .charger_on(charger_on), .charger_restart(charger_restart),
    .termination_enabled(termination_enabled),
    .thermistor_curve_select(thermistor_curve_select),
    .precharge_threshold_select(precharge_threshold_select),
    .precharge_threshold_mv(precharge_threshold_mv),
    .charge_voltage_select(charge_voltage_select), .charge_voltage_mv(charge_voltage_mv),
    .charge_timer_expired(charge_timer_expired),
    .precharge_timer_expired(precharge_timer_expired));

// ### bccs_regs_test.sv
// self-checking bench for the charger register bank
`timescale 1ns/10ps
module bccs_regs_test;
    import bccs_pkg::*;
    logic        clock = 0;
    logic        reset = 1;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    logic        in_pre = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  st_in = 8'h00;
    logic [7:0]  reg_rdata;
    logic        chg_on, rst_out, term_en, curve, pre_sel, t_exp, p_exp;
    logic [11:0] pre_mv;
    logic [1:0]  v_sel;
    logic [12:0] v_mv;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;
    int          na, nb, nc;

    bccs_regs #(.TICK_CYCLES(32'h0000_0008), .PRE_SECONDS(16'h0003)) bccs_regs_inst (
        .clock(clock), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .die_heat_cutback_flag(st_in[7]), .load_priority_loop_active(st_in[6]),
        .battery_heat_pause_flag(st_in[5]), .end_current_reached(st_in[4]),
        .charging_now(st_in[3]), .in_precharge(in_pre), .thermistor_fault_flag(st_in[0]),
        .charger_on(chg_on), .charger_restart(rst_out), .termination_enabled(term_en),
        .thermistor_curve_select(curve), .precharge_threshold_select(pre_sel),
        .precharge_threshold_mv(pre_mv), .charge_voltage_select(v_sel),
        .charge_voltage_mv(v_mv), .charge_timer_expired(t_exp),
        .precharge_timer_expired(p_exp));

    // clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock) #1;
        reg_wr = 1'b0;
        @(posedge clock) #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clock) #1;
        reg_rd = 1'b0;
        check({8'h00, reg_rdata}, {8'h00, exp}, "read data");
    endtask : rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc
    // restart pulse, then charge in precharge until expiry, counting cycles
    task automatic measure(input logic [7:0] ctl, input logic [7:0] loops, output int n);
        st_in = 8'h00; // no charging, so no timer runs before loops are set
        wr(8'h04, ctl | 8'h08);
        check({14'h0000, chg_on, rst_out}, 16'h0001, "held off in restart");
        wr(8'h04, ctl);
        check({14'h0000, t_exp, p_exp}, 16'h0000, "restart clears expiry");
        in_pre = 1'b1;
        st_in = loops | 8'h08;
        n = 0;
        while (p_exp !== 1'b1 && n < 200)
        begin
            wait_cyc(1);
            n++;
        end
    endtask : measure
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        check({15'h0000, chg_on}, 16'h0001, "charger on");
        check({14'h0000, curve, term_en}, 16'h0003, "curve and term");
        check({3'h0, v_mv}, 16'h1004, "charge mv");
        check({4'h0, pre_mv}, 16'h0b54, "pre mv");
        rd(8'h04, 8'hb1);
        rd(8'h05, 8'h80);
        rd(8'h03, 8'h00);
        rd(8'h22, 8'h00);
    endtask : t_reset
    task automatic t_fields;
        logic [12:0] mv [4] = '{13'h1004, 13'h1036, 13'h1068, 13'h1068};
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h05, 8'(8'h40 | (i << 4)));
            check({pre_sel, v_sel, v_mv}, {1'b1, 2'(i), mv[i]}, "charge mv");
            check({4'h0, pre_mv}, 16'h09c4, "pre mv");
            rd(8'h05, 8'(8'h40 | (i << 4)));
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h04, 8'((i << 6) | 8'h21));
            rd(8'h04, 8'((i << 6) | 8'h21));
            check({15'h0000, curve}, 16'h0000, "curve");
        end
        wr(8'h04, 8'hb0);
        check({15'h0000, chg_on}, 16'h0000, "charger off");
        wr(8'h05, 8'h80);
        wr(8'h04, 8'hb1);
    endtask : t_fields
    task automatic t_status;
        int bits [6] = '{7, 6, 5, 4, 3, 0};
        foreach (bits[i])
        begin
            st_in = 8'h01 << bits[i];
            wait_cyc(4);
            wr(8'h03, 8'hff);
            rd(8'h03, 8'h01 << bits[i]);
            rd(8'h03, 8'h01 << bits[i]);
        end
        wr(8'h04, 8'hb5);
        st_in = 8'h10;
        wait_cyc(4);
        check({15'h0000, term_en}, 16'h0000, "term off");
        rd(8'h03, 8'h00);
        st_in = 8'h00;
        wr(8'h04, 8'hb1);
    endtask : t_status
    task automatic t_timers;
        measure(8'hb1, 8'h00, na);
        wait_cyc(2);
        check({15'h0000, chg_on}, 16'h0000, "off after expiry");
        rd(8'h03, 8'h0e);
        measure(8'hb1, 8'h80, nb);
        wr(8'h05, 8'h00);
        measure(8'hb1, 8'h80, nc);
        // full rate needs 21 to 28 cycles, half rate 37 or more
        check({15'h0000, na < 33 && nc < 33 && nb > 34}, 16'h0001, "slow timers");
        wr(8'h05, 8'h80);
        measure(8'hb3, 8'h00, na);
        check({15'h0000, p_exp}, 16'h0000, "hold pauses");
        measure(8'h91, 8'h00, na);
        check({15'h0000, p_exp}, 16'h0000, "timers off");
        st_in = 8'h00;
        in_pre = 0;
    endtask : t_timers
    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic end_of_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (6) @(posedge clock);
        #1;
        reset = 0;
        wait_cyc(1);
        t_reset();
        t_fields();
        t_status();
        t_timers();
        end_of_test();
    end
endmodule : bccs_regs_test
